// [boot_loader_pkg.sv]
// Constants and types for the serial boot loader protocol engine
package boot_loader_pkg;
	localparam logic [7:0] MATCH_BYTE = 8'h5A;
	localparam logic [7:0] BAUD_KEEP = 8'h28;
	localparam logic [7:0] ERR_BAUD = 8'h62;
	localparam logic [7:0] ERR_CMD = 8'h63;
	localparam logic [7:0] CMD_FLASH = 8'h30;
	localparam logic [7:0] CMD_RAM = 8'h60;
	localparam logic [7:0] REC_MARK = 8'h3A;
	localparam logic [7:0] ERASED = 8'hFF;
	localparam logic [15:0] BLANK_LO = 16'hFFE0;
	localparam logic [7:0] REC_DATA = 8'h00;
	localparam logic [7:0] REC_END = 8'h01;
	localparam logic [1:0] ERR_REPEAT = 2'h3;
	localparam int CLK_HZ = 200_000_000;
	localparam int INIT_BPS = 9600;
	localparam int INIT_DIV = CLK_HZ / INIT_BPS;
	localparam logic [17:0] INIT_DIV_T = 18'(INIT_DIV);
	localparam logic [15:0] MEM_DEPTH = 16'h0400;
	typedef enum {
		S_HUNT, S_ECHO_MATCH, S_BAUD, S_ECHO_BAUD, S_CMD, S_ECHO_CMD, S_ERR,
		S_ADDR, S_BLANK, S_READ_N, S_PASS, S_MARK, S_REC, S_SUM, S_SUM_HI,
		S_SUM_LO, S_JUMP, S_HALT
	} state_e;
endpackage : boot_loader_pkg

// [boot_mem.sv]
// Device memory seen by the loader: one write port, registered read data
`timescale 1ns/100ps
`default_nettype none
module boot_mem
(
	input wire logic clk,
	input wire logic we,
	input wire logic [15:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [15:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:1023];
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem[i] = boot_loader_pkg::ERASED;
	end
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr[9:0]] <= wdata;
	end
	// Upper address bits fold onto the small array, so FFE0H lands near the top
	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr[9:0]];
	end
endmodule : boot_mem
`default_nettype wire

// [boot_loader.sv]
// Serial boot loader engine: byte stream in, byte replies out
`timescale 1ns/100ps
`default_nettype none
module boot_loader
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_ERROR,
	input wire logic RX_MATCHED,
	input wire logic [7:0] BAUD_OK_CODE,
	input wire logic TX_READY,
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	output logic BAUD_INIT,
	output logic BAUD_SWITCH,
	output logic [7:0] BAUD_CODE,
	output logic HALTED,
	output logic JUMP,
	output logic [15:0] JUMP_ADDR
);
	boot_loader_pkg::state_e state;
	logic [7:0] tx_byte;
	logic tx_busy;
	logic [1:0] err_cnt;
	logic [7:0] err_code;
	logic ram_mode;
	logic [1:0] addr_idx;
	logic [15:0] cnt_addr;
	logic [15:0] cmp_addr;
	logic [15:0] raddr;
	logic [7:0] rdata;
	logic rd_wait;
	logic [7:0] pass_left;
	logic blank;
	logic [2:0] rec_field;
	logic [7:0] rec_len;
	logic [15:0] rec_addr;
	logic [7:0] rec_type;
	logic [7:0] rec_sum;
	logic [15:0] transfer_checksum;
	logic first_rec;
	logic mem_we;
	logic [15:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic send_done;
	logic [7:0] rx_b;
	logic rx_ok;
	assign rx_b = RX_DATA;
	assign rx_ok = RX_VALID && !RX_ERROR;
	assign TX_VALID = tx_busy;
	assign send_done = tx_busy && TX_READY;
	assign HALTED = (state == boot_loader_pkg::S_HALT);
	boot_mem u_mem
	(
		.clk(CLK),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(raddr),
		.rdata(rdata)
	);
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state <= boot_loader_pkg::S_HUNT;
			tx_busy <= 1'b0;
			TX_DATA <= 8'h00;
			tx_byte <= 8'h00;
			err_cnt <= 2'h0;
			err_code <= 8'h00;
			ram_mode <= 1'b0;
			addr_idx <= 2'h0;
			cnt_addr <= 16'h0000;
			cmp_addr <= 16'h0000;
			raddr <= 16'h0000;
			rd_wait <= 1'b0;
			pass_left <= 8'h00;
			blank <= 1'b1;
			rec_field <= 3'h0;
			rec_len <= 8'h00;
			rec_addr <= 16'h0000;
			rec_type <= 8'h00;
			rec_sum <= 8'h00;
			transfer_checksum <= 16'h0000;
			first_rec <= 1'b1;
			mem_we <= 1'b0;
			mem_waddr <= 16'h0000;
			mem_wdata <= 8'h00;
			BAUD_INIT <= 1'b0;
			BAUD_SWITCH <= 1'b0;
			BAUD_CODE <= 8'h00;
			JUMP <= 1'b0;
			JUMP_ADDR <= 16'h0000;
		end
		else
		begin
			BAUD_INIT <= 1'b0;
			BAUD_SWITCH <= 1'b0;
			JUMP <= 1'b0;
			mem_we <= 1'b0;
			if (send_done)
				tx_busy <= 1'b0;
			case (state)
				boot_loader_pkg::S_HUNT:
				begin
					// Matching byte locks rate; miss stays silent
					if (RX_VALID && RX_MATCHED && rx_b == boot_loader_pkg::MATCH_BYTE)
					begin
						BAUD_INIT <= 1'b1;
						TX_DATA <= boot_loader_pkg::MATCH_BYTE;
						tx_busy <= 1'b1;
						state <= boot_loader_pkg::S_ECHO_MATCH;
					end
				end
				boot_loader_pkg::S_ECHO_MATCH:
					if (send_done)
						state <= boot_loader_pkg::S_BAUD;
				boot_loader_pkg::S_BAUD:
				begin
					if (RX_VALID)
					begin
						// Valid code echoes, else 62H thrice
						if (!RX_ERROR && rx_b == BAUD_OK_CODE)
						begin
							TX_DATA <= rx_b;
							BAUD_CODE <= rx_b;
							tx_busy <= 1'b1;
							state <= boot_loader_pkg::S_ECHO_BAUD;
						end
						else
						begin
							err_code <= boot_loader_pkg::ERR_BAUD;
							err_cnt <= 2'h0;
							state <= boot_loader_pkg::S_ERR;
						end
					end
				end
				boot_loader_pkg::S_ECHO_BAUD:
				begin
					// Rate changes only once the echo has gone
					if (send_done)
					begin
						BAUD_SWITCH <= 1'b1;
						state <= boot_loader_pkg::S_CMD;
					end
				end
				boot_loader_pkg::S_CMD:
				begin
					if (RX_VALID)
					begin
						// Flash or RAM command, else 63H thrice
						if (!RX_ERROR && (rx_b == boot_loader_pkg::CMD_FLASH ||
							rx_b == boot_loader_pkg::CMD_RAM))
						begin
							ram_mode <= (rx_b == boot_loader_pkg::CMD_RAM);
							TX_DATA <= rx_b;
							tx_busy <= 1'b1;
							state <= boot_loader_pkg::S_ECHO_CMD;
						end
						else
						begin
							err_code <= boot_loader_pkg::ERR_CMD;
							err_cnt <= 2'h0;
							state <= boot_loader_pkg::S_ERR;
						end
					end
				end
				boot_loader_pkg::S_ECHO_CMD:
				begin
					if (send_done)
					begin
						addr_idx <= 2'h0;
						first_rec <= 1'b1;
						transfer_checksum <= 16'h0000;
						state <= boot_loader_pkg::S_ADDR;
					end
				end
				boot_loader_pkg::S_ERR:
				begin
					// Error code goes out three times, then halt
					if (!tx_busy || send_done)
					begin
						if (err_cnt == boot_loader_pkg::ERR_REPEAT)
						begin
							tx_busy <= 1'b0;
							state <= boot_loader_pkg::S_HALT;
						end
						else
						begin
							TX_DATA <= err_code;
							tx_busy <= 1'b1;
							err_cnt <= err_cnt + 2'h1;
						end
					end
				end
				boot_loader_pkg::S_ADDR:
				begin
					if (RX_VALID)
					begin
						// Receive error on an address byte halts silently
						if (RX_ERROR)
							state <= boot_loader_pkg::S_HALT;
						else
						begin
							// Bytes arrive hi/lo count, then hi/lo start
							case (addr_idx)
								2'h0: cnt_addr[15:8] <= rx_b;
								2'h1: cnt_addr[7:0] <= rx_b;
								2'h2: cmp_addr[15:8] <= rx_b;
								default: cmp_addr[7:0] <= rx_b;
							endcase
							addr_idx <= addr_idx + 2'h1;
							if (addr_idx == 2'h3)
							begin
								raddr <= boot_loader_pkg::BLANK_LO;
								blank <= 1'b1;
								rd_wait <= 1'b1;
								state <= boot_loader_pkg::S_BLANK;
							end
						end
					end
				end
				boot_loader_pkg::S_BLANK:
				begin
					// Scan top 32 bytes; any non-FF byte means programmed
					rd_wait <= 1'b0;
					if (!rd_wait)
					begin
						if (rdata != boot_loader_pkg::ERASED)
							blank <= 1'b0;
						if (raddr == 16'hFFFF)
						begin
							raddr <= cnt_addr;
							rd_wait <= 1'b1;
							state <= boot_loader_pkg::S_READ_N;
						end
						else
						begin
							raddr <= raddr + 16'h0001;
							rd_wait <= 1'b1;
						end
					end
				end
				boot_loader_pkg::S_READ_N:
				begin
					rd_wait <= 1'b0;
					if (!rd_wait)
					begin
						pass_left <= rdata;
						raddr <= cmp_addr;
						rd_wait <= 1'b1;
						if (blank || rdata == 8'h00)
							state <= boot_loader_pkg::S_MARK;
						else
							state <= boot_loader_pkg::S_PASS;
					end
				end
				boot_loader_pkg::S_PASS:
				begin
					rd_wait <= 1'b0;
					if (RX_VALID && !rd_wait)
					begin
						// Each byte must match memory, else silent halt
						if (RX_ERROR || rx_b != rdata)
							state <= boot_loader_pkg::S_HALT;
						else
						begin
							pass_left <= pass_left - 8'h01;
							raddr <= raddr + 16'h0001;
							rd_wait <= 1'b1;
							if (pass_left == 8'h01)
								state <= boot_loader_pkg::S_MARK;
						end
					end
				end
				boot_loader_pkg::S_MARK:
				begin
					// Error-free bytes before the record mark are dropped; a receive error halts
					if (RX_VALID && RX_ERROR)
						state <= boot_loader_pkg::S_HALT;
					else if (rx_ok && rx_b == boot_loader_pkg::REC_MARK)
					begin
						rec_field <= 3'h0;
						rec_sum <= 8'h00;
						state <= boot_loader_pkg::S_REC;
					end
				end
				boot_loader_pkg::S_REC:
				begin
					if (RX_VALID)
					begin
						if (RX_ERROR)
							state <= boot_loader_pkg::S_HALT;
						else
						begin
							rec_sum <= rec_sum + rx_b;
							case (rec_field)
								3'h0: rec_len <= rx_b;
								3'h1: rec_addr[15:8] <= rx_b;
								3'h2: rec_addr[7:0] <= rx_b;
								3'h3:
								begin
									rec_type <= rx_b;
									if (rx_b != boot_loader_pkg::REC_DATA &&
										rx_b != boot_loader_pkg::REC_END)
										state <= boot_loader_pkg::S_HALT;
									else if (first_rec && rx_b == boot_loader_pkg::REC_DATA)
									begin
										first_rec <= 1'b0;
										JUMP_ADDR <= rec_addr;
									end
								end
								3'h4:
								begin
									if (rec_len != 8'h00)
									begin
										// Data byte stored at record address
										mem_we <= 1'b1;
										mem_waddr <= rec_addr;
										mem_wdata <= rx_b;
										transfer_checksum <= transfer_checksum + {8'h00, rx_b};
										rec_addr <= rec_addr + 16'h0001;
										rec_len <= rec_len - 8'h01;
									end
									else
									begin
										// Record checksum must bring sum to zero
										if (8'(rec_sum + rx_b) != 8'h00)
											state <= boot_loader_pkg::S_HALT;
										else if (rec_type == boot_loader_pkg::REC_END)
											state <= boot_loader_pkg::S_SUM;
										else
											state <= boot_loader_pkg::S_MARK;
									end
								end
								default: state <= boot_loader_pkg::S_HALT;
							endcase
							if (rec_field != 3'h4)
								rec_field <= rec_field + 3'h1;
						end
					end
				end
				boot_loader_pkg::S_SUM:
				begin
					// Sum ready after end record; upper byte first
					TX_DATA <= transfer_checksum[15:8];
					tx_busy <= 1'b1;
					state <= boot_loader_pkg::S_SUM_HI;
				end
				boot_loader_pkg::S_SUM_HI:
				begin
					if (send_done)
					begin
						TX_DATA <= transfer_checksum[7:0];
						tx_busy <= 1'b1;
						state <= boot_loader_pkg::S_SUM_LO;
					end
				end
				boot_loader_pkg::S_SUM_LO:
				begin
					// Flash waits for a command, RAM jumps
					if (send_done)
						state <= ram_mode ? boot_loader_pkg::S_JUMP : boot_loader_pkg::S_CMD;
				end
				boot_loader_pkg::S_JUMP:
				begin
					JUMP <= 1'b1;
					state <= boot_loader_pkg::S_HALT;
				end
				default:
				begin
					tx_busy <= 1'b0;
				end
			endcase
		end
	end
	property p_halt_quiet;
		@(posedge CLK) disable iff (RST)
		HALTED |=> !TX_VALID;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("tx while halted");
	property p_switch_after_echo;
		@(posedge CLK) disable iff (RST)
		BAUD_SWITCH |-> $past(state) == boot_loader_pkg::S_ECHO_BAUD && $past(send_done);
	endproperty
	a_switch_after_echo: assert property (p_switch_after_echo) else $error("early switch");
	property p_match_echo;
		@(posedge CLK) disable iff (RST)
		BAUD_INIT |-> TX_VALID && TX_DATA == boot_loader_pkg::MATCH_BYTE;
	endproperty
	a_match_echo: assert property (p_match_echo) else $error("no match echo");
	property p_baud_err;
		@(posedge CLK) disable iff (RST)
		(state == boot_loader_pkg::S_ERR && err_code == boot_loader_pkg::ERR_BAUD && TX_VALID)
			|-> TX_DATA == 8'h62;
	endproperty
	a_baud_err: assert property (p_baud_err) else $error("bad baud error code");
	property p_cmd_err;
		@(posedge CLK) disable iff (RST)
		(state == boot_loader_pkg::S_ERR && err_code == boot_loader_pkg::ERR_CMD && TX_VALID)
			|-> TX_DATA == 8'h63;
	endproperty
	a_cmd_err: assert property (p_cmd_err) else $error("bad cmd error code");
	property p_sum_order;
		@(posedge CLK) disable iff (RST)
		(state == boot_loader_pkg::S_SUM_HI && send_done)
			|=> TX_VALID && TX_DATA == transfer_checksum[7:0];
	endproperty
	a_sum_order: assert property (p_sum_order) else $error("sum order");
	property p_jump_ram;
		@(posedge CLK) disable iff (RST)
		JUMP |-> ram_mode ##1 HALTED;
	endproperty
	a_jump_ram: assert property (p_jump_ram) else $error("jump outside RAM mode");
	property p_data_silent;
		@(posedge CLK) disable iff (RST)
		(state == boot_loader_pkg::S_MARK || state == boot_loader_pkg::S_REC) |-> !TX_VALID;
	endproperty
	a_data_silent: assert property (p_data_silent) else $error("echo in data phase");
	property p_tx_hold;
		@(posedge CLK) disable iff (RST)
		(TX_VALID && !TX_READY) |=> TX_VALID && $stable(TX_DATA);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
endmodule : boot_loader
`default_nettype wire

// [ctrl_model.sv]
// Byte-level model of the external programming controller
`timescale 1ns/100ps
`default_nettype none
module ctrl_model
(
	input wire logic clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_error,
	output logic rx_matched,
	output logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic baud_switch,
	input wire logic jump
);
	logic [7:0] q[$];
	int n_tx;
	int sw_at;
	int n_jump;
	logic slow;
	logic [1:0] ph;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_error = 1'b0;
		rx_matched = 1'b0;
		tx_ready = 1'b1;
		slow = 1'b0;
		ph = 2'h0;
	end
	// Slow mode accepts one reply byte every fourth cycle
	always @(negedge clk)
	begin
		ph <= ph + 2'h1;
		tx_ready <= !slow || ph == 2'h3;
	end
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
		begin
			q.push_back(tx_data);
			n_tx++;
		end
		if (baud_switch)
			sw_at = n_tx;
		if (jump)
			n_jump++;
	end
	task clr();
		q = {};
		n_tx = 0;
		sw_at = -1;
		n_jump = 0;
	endtask : clr
	// One byte, spaced, line scrambled after
	task send(input logic [7:0] b, input logic err, input logic m);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data = b;
		rx_error = err;
		rx_matched = m;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~b;
		rx_error = 1'b0;
		rx_matched = 1'b0;
		repeat (4) @(negedge clk);
	endtask : send
endmodule : ctrl_model
`default_nettype wire

// [serial_boot_loader_protocol_bench.sv]
// Self-checking bench for the serial boot loader engine
`timescale 1ns/100ps
`default_nettype none
module serial_boot_loader_protocol_bench;
	logic CLK;
	logic RST;
	logic RX_VALID;
	logic [7:0] RX_DATA;
	logic RX_ERROR;
	logic RX_MATCHED;
	logic TX_READY;
	logic TX_VALID;
	logic [7:0] TX_DATA;
	logic BAUD_INIT;
	logic BAUD_SWITCH;
	logic [7:0] BAUD_CODE;
	logic HALTED;
	logic JUMP;
	logic [15:0] JUMP_ADDR;
	int fails;
	int n_checks;
	int cyc;
	int n_init;
	boot_loader i_boot_loader (.CLK(CLK), .RST(RST), .RX_VALID(RX_VALID),
		.RX_DATA(RX_DATA), .RX_ERROR(RX_ERROR), .RX_MATCHED(RX_MATCHED),
		.BAUD_OK_CODE(boot_loader_pkg::BAUD_KEEP), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
		.TX_DATA(TX_DATA), .BAUD_INIT(BAUD_INIT), .BAUD_SWITCH(BAUD_SWITCH),
		.BAUD_CODE(BAUD_CODE), .HALTED(HALTED), .JUMP(JUMP), .JUMP_ADDR(JUMP_ADDR));
	ctrl_model i_ctrl_model (.clk(CLK), .rx_valid(RX_VALID), .rx_data(RX_DATA),
		.rx_error(RX_ERROR), .rx_matched(RX_MATCHED), .tx_ready(TX_READY),
		.tx_valid(TX_VALID), .tx_data(TX_DATA), .baud_switch(BAUD_SWITCH), .jump(JUMP));
	always #2.5 CLK = ~CLK;
	task summarize();
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	// Longest run is well under this
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			summarize();
		end
	end
	always @(posedge CLK)
	begin
		if (BAUD_INIT)
			n_init++;
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task tx(input logic [7:0] exp);
		int k;
		k = 0;
		while (i_ctrl_model.q.size() == 0 && k < 3000)
		begin
			@(posedge CLK);
			k++;
		end
		// Step off the edge so the design's state has settled
		@(negedge CLK);
		if (i_ctrl_model.q.size() == 0)
			check(16'h0100, {8'h00, exp});
		else
			check({8'h00, i_ctrl_model.q.pop_front()}, {8'h00, exp});
	endtask : tx
	// Nothing may come back in this stretch
	task quiet();
		repeat (300) @(posedge CLK);
		check(16'(i_ctrl_model.q.size()), 16'h0000);
	endtask : quiet
	task send(input logic [7:0] b);
		i_ctrl_model.send(b, 1'b0, 1'b0);
	endtask : send
	task start();
		@(negedge CLK);
		RST = 1'b1;
		repeat (4) @(negedge CLK);
		RST = 1'b0;
		i_ctrl_model.clr();
		n_init = 0;
		send(8'h5A);
		quiet();
		i_ctrl_model.send(8'h5A, 1'b0, 1'b1);
		tx(8'h5A);
		check(16'(n_init), 16'h0001);
		send(8'h28);
		tx(8'h28);
		repeat (5) @(posedge CLK);
		check(16'(i_ctrl_model.sw_at), 16'h0002);
		check({8'h00, BAUD_CODE}, 16'h0028);
	endtask : start
	// Password count and compare start, then blank scan time
	task addrs(input logic [15:0] a, input logic [15:0] b);
		send(a[15:8]);
		send(a[7:0]);
		send(b[15:8]);
		send(b[7:0]);
		repeat (100) @(posedge CLK);
	endtask : addrs
	task rec(input logic [7:0] n, input logic [15:0] a, input logic [7:0] t,
		input logic [15:0] d, input logic bad);
		logic [7:0] s;
		s = n + a[15:8] + a[7:0] + t;
		send(8'h3A);
		send(n);
		send(a[15:8]);
		send(a[7:0]);
		send(t);
		if (n == 8'h02)
		begin
			send(d[15:8]);
			s = s + d[15:8];
		end
		if (n != 8'h00)
		begin
			send(d[7:0]);
			s = s + d[7:0];
		end
		send((8'h00 - s) ^ {7'h00, bad});
	endtask : rec
	task t_flash();
		start();
		send(8'h30);
		tx(8'h30);
		addrs(16'hFFE0, 16'hFFE1);
		send(8'h00);
		send(8'h11);
		rec(8'h02, 16'hFFE0, 8'h00, 16'h015C, 1'b0);
		rec(8'h01, 16'h0010, 8'h00, 16'h0012, 1'b0);
		check(16'(i_ctrl_model.q.size()), 16'h0000);
		rec(8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0);
		tx(8'h00);
		tx(8'h6F);
		send(8'h60);
		tx(8'h60);
		check({15'h0000, HALTED}, 16'h0000);
	endtask : t_flash
	task t_ram();
		start();
		send(8'h60);
		tx(8'h60);
		addrs(16'hFFE0, 16'hFFE1);
		send(8'h5C);
		repeat (10) @(posedge CLK);
		i_ctrl_model.slow = 1'b1;
		rec(8'h01, 16'h0020, 8'h00, 16'h00AB, 1'b0);
		rec(8'h01, 16'h0030, 8'h00, 16'h0001, 1'b0);
		rec(8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0);
		tx(8'h00);
		tx(8'hAC);
		repeat (20) @(posedge CLK);
		i_ctrl_model.slow = 1'b0;
		check(16'(i_ctrl_model.n_jump), 16'h0001);
		check(JUMP_ADDR, 16'h0020);
	endtask : t_ram
	task t_halts();
		start();
		send(8'h30);
		tx(8'h30);
		addrs(16'hFFE0, 16'hFFE1);
		send(8'h5D);
		rec(8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0);
		quiet();
		check({15'h0000, HALTED}, 16'h0001);
		start();
		send(8'h55);
		tx(8'h63);
		tx(8'h63);
		tx(8'h63);
		check({15'h0000, HALTED}, 16'h0001);
		start();
		send(8'h30);
		tx(8'h30);
		i_ctrl_model.send(8'hFF, 1'b1, 1'b0);
		quiet();
		check({15'h0000, HALTED}, 16'h0001);
		start();
		send(8'h30);
		tx(8'h30);
		addrs(16'hFFE0, 16'hFFE1);
		send(8'h5C);
		rec(8'h01, 16'h0040, 8'h00, 16'h0077, 1'b1);
		quiet();
		check({15'h0000, HALTED}, 16'h0001);
	endtask : t_halts
	task t_bad_baud();
		@(negedge CLK);
		RST = 1'b1;
		repeat (4) @(negedge CLK);
		RST = 1'b0;
		i_ctrl_model.clr();
		i_ctrl_model.send(8'h5A, 1'b0, 1'b1);
		tx(8'h5A);
		send(8'h99);
		tx(8'h62);
		tx(8'h62);
		tx(8'h62);
		check({15'h0000, HALTED}, 16'h0001);
		i_ctrl_model.send(8'h5A, 1'b0, 1'b1);
		quiet();
	endtask : t_bad_baud
	initial
	begin
		CLK = 1'b0;
		RST = 1'b1;
		fails = 0;
		n_checks = 0;
		cyc = 0;
		t_flash();
		t_ram();
		t_halts();
		t_bad_baud();
		summarize();
	end
endmodule : serial_boot_loader_protocol_bench
`default_nettype wire
